/* File: rtl/cmo_pkg.sv */
// Purpose: Shared constants for the CAN message object block.
// Assumes: 40 MHz clock, APB register access, 32-bit data.
// Notes: Offsets are byte addresses; fields give the low bit position.
package cmo_pkg;

  // Clock and millisecond timing.
  localparam int unsigned CLK_PERIOD_NS = 25;
  localparam int unsigned MS_TIME_NS = 1_000_000;
  localparam int unsigned MS_CYCLES = MS_TIME_NS / CLK_PERIOD_NS;

  // Register offsets.
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_ID = 8'h04;
  localparam logic [7:0] OFS_PERIOD = 8'h08;
  localparam logic [7:0] OFS_DEPTH = 8'h0C;
  localparam logic [7:0] OFS_STATUS = 8'h10;
  localparam logic [7:0] OFS_WDATA_LO = 8'h14;
  localparam logic [7:0] OFS_WDATA_HI = 8'h18;
  localparam logic [7:0] OFS_RDATA_LO = 8'h1C;
  localparam logic [7:0] OFS_RDATA_HI = 8'h20;

  // Control fields.
  localparam int CTRL_RUN = 0;
  localparam int CTRL_EXT = 1;
  localparam int CTRL_CHG = 2;
  localparam int CTRL_ARR = 3;
  localparam int CTRL_TYPE_LSB = 4;
  localparam int CTRL_LEN_LSB = 8;

  // Depth fields.
  localparam int DEPTH_W = 5;
  localparam int DEPTH_RD_LSB = 0;
  localparam int DEPTH_WR_LSB = 8;

  // Status fields.
  localparam int ST_TIMEOUT = 0;
  localparam int ST_OVERFLOW = 1;
  localparam int ST_RXLOST = 2;
  localparam int ST_SUSPEND = 3;
  localparam int ST_RCNT_LSB = 8;
  localparam int ST_WCNT_LSB = 16;

  // Values after reset.
  localparam logic [3:0] LEN_RESET = 4'h8;
  localparam logic [15:0] PERIOD_RESET = 16'h0000;
  localparam logic [4:0] RDEP_RESET = 5'h0A;
  localparam logic [4:0] WDEP_RESET = 5'h0A;

  // Communication types.
  localparam logic [2:0] CT_RX_UNSOL = 3'h0;
  localparam logic [2:0] CT_RX_POLL = 3'h1;
  localparam logic [2:0] CT_RX_CALL = 3'h2;
  localparam logic [2:0] CT_TX_PERIODIC = 3'h3;
  localparam logic [2:0] CT_TX_RESPOND = 3'h4;
  localparam logic [2:0] CT_TX_CALL = 3'h5;
  localparam logic [2:0] CT_TX_WAVE = 3'h6;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b01,
    ST_SEND = 2'b10
  } cmo_state_type;

endpackage

/* File: rtl/cmo_object.sv */
// Purpose: One CAN message object bound to a single identifier.
// Assumes: A protocol controller on the same clock moves whole frames.
// Notes: Registers are reached over APB with zero wait states.
//
// Decided for this implementation: the APB slave port and the register addresses.
`timescale 1ns/1ps
module cmo_object
  import cmo_pkg::*;
#(
  parameter int unsigned TICK_CYCLES = MS_CYCLES,
  parameter int unsigned RQ_DEPTH = 16,
  parameter int unsigned WQ_DEPTH = 16
) (
  // Clock and reset.
  input wire logic clock_in,
  input wire logic rst_in,
  // APB slave.
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [7:0] paddr_in,
  input wire logic [31:0] pwdata_in,
  output logic [31:0] prdata_out,
  output logic pready_out,
  output logic pslverr_out,
  // Frames to the protocol controller.
  output logic tx_valid_out,
  input wire logic tx_ready_in,
  output logic [28:0] tx_id_out,
  output logic tx_ext_out,
  output logic tx_rtr_out,
  output logic [3:0] tx_dlc_out,
  output logic [63:0] tx_data_out,
  // Frames from the protocol controller.
  input wire logic rx_valid_in,
  input wire logic [28:0] rx_id_in,
  input wire logic rx_ext_in,
  input wire logic rx_rtr_in,
  input wire logic [63:0] rx_data_in
);

  localparam int RAW = $clog2(RQ_DEPTH);
  localparam int WAW = $clog2(WQ_DEPTH);

  function automatic logic f_rx_type(input logic [2:0] ct);
    f_rx_type = (ct == CT_RX_UNSOL) || (ct == CT_RX_POLL) ||
                (ct == CT_RX_CALL);
  endfunction

  function automatic logic f_wdog_type(input logic [2:0] ct);
    f_wdog_type = (ct == CT_RX_UNSOL) || (ct == CT_TX_RESPOND);
  endfunction

  function automatic logic [63:0] f_len_mask(input logic [3:0] len);
    logic [63:0] m;
    m = 64'h0000_0000_0000_0000;
    for (int i = 0; i < 8; i++) begin
      if (4'(i) < len) begin
        m[i*8 +: 8] = 8'hFF;
      end
    end
    f_len_mask = m;
  endfunction

  // Configuration and status state.
  logic run_q, ext_q, chg_q, arr_q;
  logic [2:0] ctype_q;
  logic [3:0] len_q;
  logic [28:0] id_q;
  logic [15:0] period_q;
  logic [4:0] rdep_q, wdep_q;
  logic [31:0] wlo_q;
  logic timeout_q, overflow_q, rxlost_q, suspend_q, await_q, resp_q;
  logic [31:0] prdata_q;
  logic err_q;
  // Queues.
  logic [63:0] rq_mem [RQ_DEPTH];
  logic [63:0] wq_mem [WQ_DEPTH];
  logic [RAW-1:0] rq_wp_q, rq_rp_q;
  logic [WAW-1:0] wq_wp_q, wq_rp_q, wave_q;
  logic [4:0] rq_cnt_q, wq_cnt_q, rq_lim, wq_lim;
  // Timing and transmit state.
  logic [31:0] tick_q;
  logic [15:0] elapsed_q;
  cmo_state_type state_q;
  logic have_tx_q, have_rx_q, tx_rtr_q;
  logic [63:0] tx_data_q, last_q, prev_rx_q;

  // Bus decode.
  logic apb_setup, apb_wr, apb_rd, wr_hi, rd_pop;
  assign apb_setup = psel_in && !penable_in;
  assign apb_wr = psel_in && penable_in && pwrite_in;
  assign apb_rd = psel_in && penable_in && !pwrite_in;
  assign wr_hi = apb_wr && (paddr_in == OFS_WDATA_HI);
  assign rd_pop = apb_rd && (paddr_in == OFS_RDATA_HI) && (rq_cnt_q != 5'h00);
  assign pready_out = 1'b1;
  assign pslverr_out = psel_in && penable_in && err_q;
  assign prdata_out = prdata_q;

  assign rq_lim = (rdep_q > 5'(RQ_DEPTH)) ? 5'(RQ_DEPTH) : rdep_q;
  assign wq_lim = (wdep_q > 5'(WQ_DEPTH)) ? 5'(WQ_DEPTH) : wdep_q;

  logic id_eq, match;
  assign id_eq = ext_q ? (rx_id_in == id_q) : (rx_id_in[10:0] == id_q[10:0]);
  assign match = rx_valid_in && run_q && id_eq && (rx_ext_in == ext_q);

  logic rx_data_hit, rx_new, rq_push, rq_drop;
  assign rx_data_hit = match && !rx_rtr_in && f_rx_type(ctype_q);
  assign rx_new = !chg_q || !have_rx_q || (rx_data_in != prev_rx_q);
  assign rq_push = rx_data_hit && rx_new && (rq_cnt_q < rq_lim);
  assign rq_drop = rx_data_hit && rx_new && (rq_cnt_q >= rq_lim);

  // no writes to a running waveform.
  logic host_push, wq_push, wq_ovf;
  assign host_push = wr_hi && !(ctype_q == CT_TX_WAVE && run_q);
  assign wq_push = host_push && (wq_cnt_q < wq_lim);
  assign wq_ovf = host_push && (wq_cnt_q >= wq_lim);

  // Timing terms.
  logic ms_tick, elapsed_done, gap_ok, due, wd_fire, wd_kick;
  assign ms_tick = (tick_q == 32'(TICK_CYCLES - 1));
  assign elapsed_done = (elapsed_q >= period_q);
  assign gap_ok = (period_q == 16'h0000) || !have_tx_q || elapsed_done;
  assign due = !have_tx_q || ((period_q != 16'h0000) && elapsed_done);
  assign wd_fire = run_q && f_wdog_type(ctype_q) &&
                   (period_q != 16'h0000) && elapsed_done;
  assign wd_kick = f_wdog_type(ctype_q) && match &&
                   (!rx_rtr_in || ctype_q == CT_TX_RESPOND);

  // Transmit selection.
  logic send, send_rtr, send_pop, send_wave, resp_clr, poll_miss;
  logic [63:0] send_data;
  always_comb begin
    send = 1'b0;
    send_rtr = 1'b0;
    send_pop = 1'b0;
    send_wave = 1'b0;
    resp_clr = 1'b0;
    poll_miss = 1'b0;
    send_data = wq_mem[wq_rp_q];
    if (run_q && state_q == ST_IDLE) begin
      case (ctype_q)
        CT_TX_RESPOND: begin
          if (resp_q) begin
            resp_clr = 1'b1;
            send = (wq_cnt_q != 5'h00);
            send_pop = send;
          end
        end
        CT_TX_PERIODIC: begin
          if (resp_q && have_tx_q) begin
            resp_clr = 1'b1;
            send = 1'b1;
            send_data = last_q;
          end else if (due && wq_cnt_q != 5'h00) begin
            send = 1'b1;
            send_pop = 1'b1;
          end else if (due && have_tx_q) begin
            send = 1'b1;
            send_data = last_q;
          end
        end
        CT_TX_CALL: begin
          if (resp_q && have_tx_q) begin
            resp_clr = 1'b1;
            send = 1'b1;
            send_data = last_q;
          end else if (wq_cnt_q != 5'h00 && gap_ok) begin
            send = 1'b1;
            send_pop = 1'b1;
          end
        end
        CT_TX_WAVE: begin
          if (due && wq_cnt_q != 5'h00) begin
            send = 1'b1;
            send_wave = 1'b1;
            send_data = wq_mem[wq_rp_q + wave_q];
          end
        end
        CT_RX_POLL: begin
          if (due && await_q) begin
            poll_miss = 1'b1;
          end else if (due && !suspend_q) begin
            send = 1'b1;
            send_rtr = 1'b1;
          end
        end
        CT_RX_CALL: begin
          if (wq_cnt_q != 5'h00 && gap_ok) begin
            send = 1'b1;
            send_rtr = 1'b1;
            send_pop = 1'b1;
          end
        end
        default: begin
          send = 1'b0;
        end
      endcase
    end
  end

  // Configuration registers.
  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      run_q <= 1'b0;
      ext_q <= 1'b0;
      chg_q <= 1'b0;
      arr_q <= 1'b0;
      ctype_q <= CT_RX_UNSOL;
      len_q <= LEN_RESET;
      id_q <= 29'h0000_0000;
      period_q <= PERIOD_RESET;
      rdep_q <= RDEP_RESET;
      wdep_q <= WDEP_RESET;
      wlo_q <= 32'h0000_0000;
    end else if (apb_wr) begin
      if (paddr_in == OFS_CTRL) begin
        run_q <= pwdata_in[CTRL_RUN];
        ext_q <= pwdata_in[CTRL_EXT];
        chg_q <= pwdata_in[CTRL_CHG];
        arr_q <= pwdata_in[CTRL_ARR];
        ctype_q <= pwdata_in[CTRL_TYPE_LSB +: 3];
        len_q <= pwdata_in[CTRL_LEN_LSB +: 4];
      end else if (paddr_in == OFS_ID) begin
        id_q <= pwdata_in[28:0];
      end else if (paddr_in == OFS_PERIOD) begin
        period_q <= pwdata_in[15:0];
      end else if (paddr_in == OFS_DEPTH) begin
        rdep_q <= pwdata_in[DEPTH_RD_LSB +: DEPTH_W];
        wdep_q <= pwdata_in[DEPTH_WR_LSB +: DEPTH_W];
      end else if (paddr_in == OFS_WDATA_LO) begin
        wlo_q <= pwdata_in;
      end
    end
  end

  // Length mask as a signal, since a call result cannot be part-selected.
  logic [63:0] len_mask;
  assign len_mask = f_len_mask(len_q);

  // Read data and error answer, latched in the setup cycle.
  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      prdata_q <= 32'h0000_0000;
      err_q <= 1'b0;
    end else if (apb_setup) begin
      err_q <= 1'b0;
      prdata_q <= 32'h0000_0000;
      if (paddr_in == OFS_CTRL) begin
        prdata_q <= {20'h0_0000, len_q, 1'b0, ctype_q,
                     arr_q, chg_q, ext_q, run_q};
      end else if (paddr_in == OFS_ID) begin
        prdata_q <= {3'h0, id_q};
      end else if (paddr_in == OFS_PERIOD) begin
        prdata_q <= {16'h0000, period_q};
      end else if (paddr_in == OFS_DEPTH) begin
        prdata_q <= {19'h0_0000, wdep_q, 3'h0, rdep_q};
      end else if (paddr_in == OFS_STATUS) begin
        prdata_q <= {11'h000, wq_cnt_q, 3'h0, rq_cnt_q, 4'h0,
                     suspend_q, rxlost_q, overflow_q, timeout_q};
      end else if (paddr_in == OFS_WDATA_LO) begin
        prdata_q <= wlo_q;
      end else if (paddr_in == OFS_WDATA_HI) begin
        prdata_q <= 32'h0000_0000;
      end else if (paddr_in == OFS_RDATA_LO) begin
        prdata_q <= rq_mem[rq_rp_q][31:0] & len_mask[31:0];
      end else if (paddr_in == OFS_RDATA_HI) begin
        prdata_q <= rq_mem[rq_rp_q][63:32] & len_mask[63:32];
      end else begin
        err_q <= 1'b1;
      end
    end
  end

  // Sticky error flags; a new event wins over a clear.
  logic [31:0] clr;
  assign clr = (apb_wr && paddr_in == OFS_STATUS) ? pwdata_in : 32'h0000_0000;
  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      timeout_q <= 1'b0;
      overflow_q <= 1'b0;
      rxlost_q <= 1'b0;
    end else begin
      timeout_q <= wd_fire || (timeout_q && !clr[ST_TIMEOUT]);
      overflow_q <= wq_ovf || (overflow_q && !clr[ST_OVERFLOW]);
      rxlost_q <= rq_drop || (rxlost_q && !clr[ST_RXLOST]);
    end
  end

  always_ff @(posedge clock_in) begin
    if (rq_push) begin
      rq_mem[rq_wp_q] <= rx_data_in;
    end
  end

  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      rq_wp_q <= '0;
      rq_rp_q <= '0;
      rq_cnt_q <= 5'h00;
      prev_rx_q <= 64'h0000_0000_0000_0000;
      have_rx_q <= 1'b0;
    end else begin
      rq_wp_q <= rq_wp_q + RAW'(rq_push);
      rq_rp_q <= rq_rp_q + RAW'(rd_pop);
      rq_cnt_q <= rq_cnt_q + 5'(rq_push) - 5'(rd_pop);
      if (rx_data_hit) begin
        prev_rx_q <= rx_data_in;
        have_rx_q <= 1'b1;
      end
    end
  end

  // Write queue.
  always_ff @(posedge clock_in) begin
    if (wq_push) begin
      wq_mem[wq_wp_q] <= {pwdata_in, wlo_q};
    end
  end

  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      wq_wp_q <= '0;
      wq_rp_q <= '0;
      wq_cnt_q <= 5'h00;
      wave_q <= '0;
    end else begin
      wq_wp_q <= wq_wp_q + WAW'(wq_push);
      wq_rp_q <= wq_rp_q + WAW'(send_pop);
      wq_cnt_q <= wq_cnt_q + 5'(wq_push) - 5'(send_pop);
      if (!run_q) begin
        wave_q <= '0;
      end else if (send_wave) begin
        wave_q <= (5'(wave_q) + 5'h01 >= wq_cnt_q) ? '0 : wave_q + 1'b1;
      end
    end
  end

  // Millisecond tick restarts with the interval, so no period runs short.
  logic tx_done, restart;
  assign tx_done = (state_q == ST_SEND) && tx_ready_in;
  assign restart = !run_q || wd_kick || wd_fire ||
                   (tx_done && !f_wdog_type(ctype_q));
  always_ff @(posedge clock_in) begin
    if (rst_in || ms_tick || restart) begin
      tick_q <= 32'h0000_0000;
    end else begin
      tick_q <= tick_q + 32'h0000_0001;
    end
  end

  always_ff @(posedge clock_in) begin
    if (rst_in || restart) begin
      elapsed_q <= 16'h0000;
    end else if (ms_tick && elapsed_q != 16'hFFFF) begin
      elapsed_q <= elapsed_q + 16'h0001;
    end
  end

  // Remote reply request and poll supervision.
  always_ff @(posedge clock_in) begin
    if (rst_in || !run_q) begin
      resp_q <= 1'b0;
      await_q <= 1'b0;
      suspend_q <= 1'b0;
    end else begin
      // remote frames ignored unless respond type or auto reply.
      if (match && rx_rtr_in && (ctype_q == CT_TX_RESPOND ||
          (arr_q && (ctype_q == CT_TX_PERIODIC ||
                     ctype_q == CT_TX_CALL)))) begin
        resp_q <= 1'b1;
      end else if (resp_clr) begin
        resp_q <= 1'b0;
      end
      if (rx_data_hit) begin
        await_q <= 1'b0;
      end else if (tx_done && tx_rtr_q && ctype_q == CT_RX_POLL) begin
        await_q <= 1'b1;
      end
      if (poll_miss) begin
        suspend_q <= 1'b1;
      end
    end
  end

  // frame handshake with the protocol controller.
  always_ff @(posedge clock_in) begin
    if (rst_in || !run_q) begin
      state_q <= ST_IDLE;
      have_tx_q <= 1'b0;
      tx_rtr_q <= 1'b0;
      tx_data_q <= 64'h0000_0000_0000_0000;
      last_q <= 64'h0000_0000_0000_0000;
    end else begin
      case (state_q)
        ST_IDLE: begin
          if (send) begin
            state_q <= ST_SEND;
            tx_rtr_q <= send_rtr;
            tx_data_q <= send_rtr ? 64'h0000_0000_0000_0000 : send_data;
          end
        end
        ST_SEND: begin
          if (tx_ready_in) begin
            state_q <= ST_IDLE;
            have_tx_q <= 1'b1;
            if (!tx_rtr_q) begin
              last_q <= tx_data_q;
            end
          end
        end
        default: begin
          state_q <= ST_IDLE;
        end
      endcase
    end
  end

  assign tx_valid_out = (state_q == ST_SEND);
  assign tx_id_out = id_q;
  assign tx_ext_out = ext_q;
  assign tx_rtr_out = tx_rtr_q;
  assign tx_dlc_out = len_q;
  assign tx_data_out = tx_data_q;

  a_rq_push_match: assert property (@(posedge clock_in) disable iff (rst_in)
    rq_push |-> (rx_ext_in == ext_q) && (ext_q ? rx_id_in == id_q :
      rx_id_in[10:0] == id_q[10:0]))
    else $error("Queued frame with foreign identifier.");
  a_rq_depth_bound: assert property (@(posedge clock_in) disable iff (rst_in)
    (rq_cnt_q <= rq_lim) || $past(rdep_q) != rdep_q)
    else $error("Read queue holds more than its depth.");
  a_wq_full_flag: assert property (@(posedge clock_in) disable iff (rst_in)
    (wr_hi && run_q == 1'b0 && wq_cnt_q >= wq_lim) |=>
      overflow_q && $stable(wq_wp_q))
    else $error("Write to full queue not flagged.");
  a_tx_dlc_len: assert property (@(posedge clock_in) disable iff (rst_in)
    tx_valid_out |-> tx_dlc_out == len_q)
    else $error("Sent length code differs from length.");
  a_wdog_timeout: assert property (@(posedge clock_in) disable iff (rst_in)
    (run_q && f_wdog_type(ctype_q) && period_q != 16'h0000 &&
     elapsed_q >= period_q) |=> timeout_q && elapsed_q == 16'h0000)
    else $error("Watchdog expiry not reported.");
  a_call_min_gap: assert property (@(posedge clock_in) disable iff (rst_in)
    ($rose(tx_valid_out) && $past(have_tx_q) && period_q != 16'h0000 &&
     !$past(resp_q) && (ctype_q == CT_TX_CALL || ctype_q == CT_RX_CALL))
      |-> $past(elapsed_q) >= period_q)
    else $error("On-call send before minimum interval.");
  a_poll_remote: assert property (@(posedge clock_in) disable iff (rst_in)
    (tx_valid_out && ctype_q == CT_RX_POLL) |-> tx_rtr_out)
    else $error("Polling object sent a data frame.");
  a_change_filter: assert property (@(posedge clock_in) disable iff (rst_in)
    (rx_data_hit && chg_q && have_rx_q && rx_data_in == prev_rx_q)
      |=> $stable(rq_wp_q))
    else $error("Unchanged data was queued.");
  a_tx_hold: assert property (@(posedge clock_in) disable iff (rst_in)
    (tx_valid_out && !tx_ready_in && run_q) |=>
      tx_valid_out && $stable(tx_data_out) && $stable(tx_rtr_out))
    else $error("Offered frame changed before acceptance.");

endmodule

/* File: dv/cmo_peer_node.sv */
// Purpose: Behavioural model of the nodes behind the protocol controller.
// Assumes: Same clock as the object; one frame per valid pulse.
// Notes: Ready toggles, so offered frames are taken promptly or slowly.
`timescale 1ns/1ps
module cmo_peer_node
  import cmo_pkg::*;
(
  // Frames from the object.
  input wire logic clock_in,
  input wire logic tx_valid_in,
  input wire logic [28:0] tx_id_in,
  input wire logic tx_ext_in,
  input wire logic tx_rtr_in,
  input wire logic [3:0] tx_dlc_in,
  input wire logic [63:0] tx_data_in,
  output logic tx_ready_out,
  // Frames to the object.
  output logic rx_valid_out,
  output logic [28:0] rx_id_out,
  output logic rx_ext_out,
  output logic rx_rtr_out,
  output logic [63:0] rx_data_out
);
  logic [98:0] log[$];
  int tlog[$];
  logic reply_on = 1'b1;
  logic [63:0] seed = 64'h0123_4567_89AB_CDEF;
  int cyc = 0;
  int answered = 0;
  always @(posedge clock_in) cyc <= cyc + 1;
  // Offers one frame for a cycle, then scrambles the released identifier and data lines.
  task automatic send(input logic [28:0] id, input logic e, r,
    input logic [63:0] d);
    @(posedge clock_in);
    rx_valid_out <= 1'b1;
    rx_id_out <= id;
    rx_ext_out <= e;
    rx_rtr_out <= r;
    rx_data_out <= d;
    @(posedge clock_in);
    rx_valid_out <= 1'b0;
    rx_id_out <= ~id;
    rx_data_out <= ~d;
  endtask
  initial begin
    tx_ready_out = 1'b0;
    {rx_valid_out, rx_ext_out, rx_rtr_out} = 3'b000;
    rx_id_out = '0;
    rx_data_out = '0;
    forever begin
      @(posedge clock_in);
      if (tx_valid_in === 1'b1 && tx_ready_out === 1'b1) begin
        log.push_back({tx_id_in, tx_ext_in, tx_rtr_in, tx_dlc_in,
          tx_data_in});
        tlog.push_back(cyc);
      end
      // Remote frames get a fresh data answer while reply_on is set.
      if (tx_valid_in === 1'b1 && tx_ready_out === 1'b1 &&
          tx_rtr_in === 1'b1 && reply_on) begin
        tx_ready_out <= 1'b0;
        seed = {seed[62:0], seed[63] ^ seed[62] ^ seed[60] ^ seed[59]};
        answered++;
        send(tx_id_in, tx_ext_in, 1'b0, seed);
      end else begin
        tx_ready_out <= ~tx_ready_out;
      end
    end
  end
endmodule

/* File: dv/testbench.sv */
// Purpose: Self-checking bench for the CAN message object.
// Assumes: The peer model answers remote frames while reply_on is set.
// Notes: A ten-cycle millisecond keeps every period short.
`timescale 1ns/1ps
module testbench
  import cmo_pkg::*;
;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic sel = 1'b0;
  logic en = 1'b0;
  logic wr = 1'b0;
  logic [7:0] adr = 8'h00;
  logic [31:0] wd = 32'h0000_0000;
  logic [31:0] rnd = 32'h0000_001B;
  logic [31:0] prd, rd;
  logic rdy, serr, err, tv, tr, te, trt, rv, re, rrt;
  logic [28:0] tid, rid, oid;
  logic [3:0] tdl;
  logic [63:0] td, rdat, e1, e2;
  int n_errors = 0;
  int n_checks = 0;
  int n0, n1, g;
  initial forever #12.5 clk = ~clk;
  cmo_object #(.TICK_CYCLES(10)) cmo_object_inst (.clock_in(clk),
    .rst_in(rst), .psel_in(sel), .penable_in(en), .pwrite_in(wr),
    .paddr_in(adr), .pwdata_in(wd), .prdata_out(prd), .pready_out(rdy),
    .pslverr_out(serr), .tx_valid_out(tv), .tx_ready_in(tr),
    .tx_id_out(tid), .tx_ext_out(te), .tx_rtr_out(trt), .tx_dlc_out(tdl),
    .tx_data_out(td), .rx_valid_in(rv), .rx_id_in(rid), .rx_ext_in(re),
    .rx_rtr_in(rrt), .rx_data_in(rdat));
  cmo_peer_node cmo_peer_inst (.clock_in(clk), .tx_valid_in(tv),
    .tx_id_in(tid), .tx_ext_in(te), .tx_rtr_in(trt), .tx_dlc_in(tdl),
    .tx_data_in(td), .tx_ready_out(tr), .rx_valid_out(rv),
    .rx_id_out(rid), .rx_ext_out(re), .rx_rtr_out(rrt), .rx_data_out(rdat));
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task chk(input string nm, input logic [63:0] got, exp);
    n_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    sel <= 1'b1;
    wr <= w;
    adr <= a;
    wd <= d;
    @(posedge clk);
    en <= 1'b1;
    do @(posedge clk); while (rdy !== 1'b1);
    rd = prd;
    err = serr;
    sel <= 1'b0;
    en <= 1'b0;
  endtask
  task rst_dut();
    rst <= 1'b1;
    repeat (5) @(posedge clk);
    rst <= 1'b0;
  endtask
  task chk_tx(input int i, input logic [63:0] d, input logic x, r);
    repeat (400) if (cmo_peer_inst.log.size() <= i) @(posedge clk);
    chk("tx_head", cmo_peer_inst.log[i][98:64], {oid, x, r, 4'h8});
    if (!r) chk("tx_data", cmo_peer_inst.log[i][63:0], d);
  endtask
  task finish_test();
    $display("Checks %0d, errors %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge clk);
    n_errors++;
    finish_test();
  end
  initial begin
    rst_dut();
    chk("dlc_reset", tdl, LEN_RESET);
    apb(1'b0, OFS_DEPTH, 32'h0000_0000);
    chk("depth", rd, {19'h0, WDEP_RESET, 3'h0, RDEP_RESET});
    apb(1'b0, 8'h24, 32'h0000_0000);
    chk("unmapped", err, 1'b1);
    // Unsolicited receive, changes only, read depth two, length four.
    rnd = lfsr(rnd);
    oid = {18'h0, rnd[10:0]};
    e1 = {rnd, lfsr(rnd)};
    e2 = ~e1;
    apb(1'b1, OFS_ID, {3'h0, oid});
    apb(1'b1, OFS_DEPTH, 32'h0000_0A02);
    apb(1'b1, OFS_PERIOD, 32'h0000_0004);
    apb(1'b1, OFS_CTRL, 32'h0000_040D);
    n0 = cmo_peer_inst.log.size();
    cmo_peer_inst.send(oid, 1'b0, 1'b0, e1);
    cmo_peer_inst.send(oid ^ 29'h1, 1'b0, 1'b0, e2);
    cmo_peer_inst.send(oid, 1'b0, 1'b0, e1);
    cmo_peer_inst.send(oid, 1'b1, 1'b0, e2);
    cmo_peer_inst.send(oid, 1'b0, 1'b1, e2);
    cmo_peer_inst.send(oid, 1'b0, 1'b0, e2);
    cmo_peer_inst.send(oid, 1'b0, 1'b0, e1);
    apb(1'b0, OFS_STATUS, 32'h0000_0000);
    chk("rx_count", rd[12:8], 5'h02);
    chk("rx_lost", rd[2], 1'b1);
    chk("no_reply", cmo_peer_inst.log.size() - n0, 0);
    apb(1'b0, OFS_RDATA_LO, 32'h0000_0000);
    chk("rd_lo", rd, e1[31:0]);
    apb(1'b0, OFS_RDATA_HI, 32'h0000_0000);
    chk("rd_hi", rd, 32'h0000_0000);
    apb(1'b1, OFS_STATUS, 32'h0000_0007);
    repeat (4) begin
      repeat (12) @(posedge clk);
      cmo_peer_inst.send(oid, 1'b0, 1'b0, e1);
    end
    apb(1'b0, OFS_STATUS, 32'h0000_0000);
    chk("wd_kept", rd[0], 1'b0);
    repeat (50) @(posedge clk);
    apb(1'b0, OFS_STATUS, 32'h0000_0000);
    chk("wd_fired", rd[0], 1'b1);
    // Transmit on call: overflow while stopped, then spaced sends.
    rst_dut();
    apb(1'b1, OFS_DEPTH, 32'h0000_0200);
    for (int i = 0; i < 3; i++) begin
      apb(1'b1, OFS_WDATA_LO, i[0] ? e2[31:0] : e1[31:0]);
      apb(1'b1, OFS_WDATA_HI, i[0] ? e2[63:32] : e1[63:32]);
    end
    apb(1'b0, OFS_STATUS, 32'h0000_0000);
    chk("overflow", rd[1], 1'b1);
    chk("wr_count", rd[20:16], 5'h02);
    rnd = lfsr(rnd);
    oid = rnd[28:0];
    apb(1'b1, OFS_ID, {3'h0, oid});
    apb(1'b1, OFS_PERIOD, 32'h0000_0003);
    n0 = cmo_peer_inst.log.size();
    apb(1'b1, OFS_CTRL, 32'h0000_085B);
    chk_tx(n0, e1, 1'b1, 1'b0);
    chk_tx(n0 + 1, e2, 1'b1, 1'b0);
    g = cmo_peer_inst.tlog[n0 + 1] - cmo_peer_inst.tlog[n0];
    chk("min_gap", g >= 30, 1'b1);
    cmo_peer_inst.send(oid, 1'b1, 1'b1, {rnd, rnd});
    chk_tx(n0 + 2, e2, 1'b1, 1'b0);
    // Periodic polling, answered for a while, then left unanswered.
    rst_dut();
    oid = {18'h0, rnd[10:0]};
    apb(1'b1, OFS_ID, {3'h0, oid});
    apb(1'b1, OFS_PERIOD, 32'h0000_0002);
    n0 = cmo_peer_inst.log.size();
    n1 = cmo_peer_inst.answered;
    apb(1'b1, OFS_CTRL, 32'h0000_0811);
    repeat (50) @(posedge clk);
    @(negedge clk);
    cmo_peer_inst.reply_on = 1'b0;
    repeat (80) @(posedge clk);
    apb(1'b0, OFS_STATUS, 32'h0000_0000);
    chk("suspend", rd[3], 1'b1);
    chk("poll_rx", rd[12:8], 5'(cmo_peer_inst.answered - n1));
    g = cmo_peer_inst.log.size() - n0;
    chk("poll_tx", g, cmo_peer_inst.answered - n1 + 1);
    chk_tx(n0, e1, 1'b0, 1'b1);
    g = cmo_peer_inst.tlog[n0 + 1] - cmo_peer_inst.tlog[n0];
    chk("period", g >= 20 && g <= 24, 1'b1);
    // Periodic transmit: nothing until the first write, then repeats.
    rst_dut();
    apb(1'b1, OFS_ID, {3'h0, oid});
    apb(1'b1, OFS_PERIOD, 32'h0000_0002);
    n0 = cmo_peer_inst.log.size();
    apb(1'b1, OFS_CTRL, 32'h0000_0831);
    repeat (40) @(posedge clk);
    chk("tx_defer", cmo_peer_inst.log.size() - n0, 0);
    apb(1'b1, OFS_WDATA_LO, e2[31:0]);
    apb(1'b1, OFS_WDATA_HI, e2[63:32]);
    chk_tx(n0, e2, 1'b0, 1'b0);
    chk_tx(n0 + 1, e2, 1'b0, 1'b0);
    // Waveform: two entries sent in turn, then the first again.
    rst_dut();
    apb(1'b1, OFS_DEPTH, 32'h0000_0200);
    for (int i = 0; i < 2; i++) begin
      apb(1'b1, OFS_WDATA_LO, i[0] ? e2[31:0] : e1[31:0]);
      apb(1'b1, OFS_WDATA_HI, i[0] ? e2[63:32] : e1[63:32]);
    end
    apb(1'b1, OFS_ID, {3'h0, oid});
    apb(1'b1, OFS_PERIOD, 32'h0000_0002);
    n0 = cmo_peer_inst.log.size();
    apb(1'b1, OFS_CTRL, 32'h0000_0861);
    chk_tx(n0, e1, 1'b0, 1'b0);
    chk_tx(n0 + 1, e2, 1'b0, 1'b0);
    chk_tx(n0 + 2, e1, 1'b0, 1'b0);
    finish_test();
  end
endmodule
